// *** verilog/pcrs_pkg.sv ***
/*
 * Package for the program counter and return stack block: register offsets,
 * field positions, reset values, vectors, command encodings and carriers.
 * Assumes a classic Wishbone register bus with 32-bit data, byte addressed.
 */
`default_nettype none
package pcrs_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int          ADDR_W        = 21;
    localparam int          PTR_W         = 5;
    localparam int          DEPTH         = 31;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0]  OFS_LOW       = 8'h00;
    localparam logic [7:0]  OFS_HLATCH    = 8'h04;
    localparam logic [7:0]  OFS_ULATCH    = 8'h08;
    localparam logic [7:0]  OFS_PTR       = 8'h0C;
    localparam logic [7:0]  OFS_TOPL      = 8'h10;
    localparam logic [7:0]  OFS_TOPH      = 8'h14;
    localparam logic [7:0]  OFS_TOPU      = 8'h18;
    localparam logic [7:0]  OFS_CTRL      = 8'h1C;
    localparam logic [7:0]  OFS_PC        = 8'h20;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int          OVF_BIT       = 7;
    localparam int          UNF_BIT       = 6;
    localparam int          CTRL_OVRST    = 0;
    localparam int          CTRL_PUSH     = 1;
    localparam int          CTRL_POP      = 2;
    localparam logic        OVRST_RESET   = 1'b1;
    localparam logic [20:0] RESET_VECTOR  = 21'h000000;
    localparam logic [20:0] HIGH_VECTOR   = 21'h000008;
    localparam logic [20:0] LOW_VECTOR    = 21'h000018;
    localparam logic [20:0] TOP_8K        = 21'h001FFF;
    localparam logic [20:0] TOP_16K       = 21'h003FFF;
    localparam logic [20:0] STEP          = 21'h000002;
    localparam logic [15:0] NOP_WORD      = 16'h0000;
    // ----------------------------------------
    // Decoder commands
    // ----------------------------------------
    typedef enum logic [3:0] {
        CMD_NEXT     = 4'h0,
        CMD_JUMP     = 4'h1,
        CMD_CALL     = 4'h2,
        CMD_RETURN   = 4'h3,
        CMD_RETLIT   = 4'h4,
        CMD_IRQ_RET  = 4'h5,
        CMD_ACK_HIGH = 4'h6,
        CMD_ACK_LOW  = 4'h7,
        CMD_HOLD     = 4'h8
    } pcrs_cmd_type;
    typedef struct packed {
        logic         valid;
        pcrs_cmd_type cmd;
        logic [20:0]  target;
    } pcrs_req_type;
    typedef struct packed {
        logic         overflow_reset;
        logic         overflow;
        logic         underflow;
    } pcrs_event_type;
endpackage
`default_nettype wire

// *** verilog/pcrs_core.sv ***
/*
 * Fetch address counter with latch registers and 31-level return stack.
 * Assumes the decoder issues at most one request per cycle and that
 * software keeps interrupts off while it touches stack registers.
 */
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcrs_core #(
    parameter logic [20:0] MEM_TOP = pcrs_pkg::TOP_16K
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire pcrs_pkg::pcrs_req_type   req_i,
    output logic [20:0]                   fetch_address_o,
    output logic                          fetch_in_range_o,
    output logic [15:0]                   fetch_mask_o,
    output pcrs_pkg::pcrs_event_type      event_o,
    output logic                          device_reset_o,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic [31:0]                   wb_dat_o,
    input  wire logic                     wb_we_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    output logic                          wb_ack_o,
    output logic                          wb_err_o
);
    import pcrs_pkg::*;

    // Elaboration stops on any MEM_TOP other than the 8K or 16K top
    if (MEM_TOP != TOP_8K && MEM_TOP != TOP_16K)
    begin : g_bad_top
        $error("MEM_TOP must be 8K or 16K top");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [20:0] fetch_address_counter;
    logic [7:0]  high_byte_latch;
    logic [4:0]  upper_byte_latch;
    logic [4:0]  pointer_value_field;
    logic [20:0] stack_mem [1:DEPTH];
    logic        stack_overflow_flag;
    logic        stack_underflow_flag;
    logic        overflow_reset_enable;
    logic        stack_full_flag;
    logic        wb_req;
    logic        wb_wr;
    logic        wb_rd;
    logic        lane0;
    logic        sw_push;
    logic        sw_pop;
    logic        hw_push;
    logic        hw_pop;
    logic        do_push;
    logic        do_pop;
    logic        ovf_event;
    logic        pop_empty;
    logic        ovf_reset;
    logic        top_write;
    logic        wr_low;
    logic        wr_hlatch;
    logic        wr_ulatch;
    logic        wr_ptr;
    logic        wr_topl;
    logic        wr_toph;
    logic        wr_topu;
    logic        wr_ctrl;
    logic        rd_low;
    logic [20:0] top_entry;
    logic [20:0] next_pc;
    logic [20:0] next_fetch;
    logic [20:0] push_value;

    // ----------------------------------------
    // Register strobes
    // ----------------------------------------
    // Writes without lane zero are answered but change nothing
    assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign lane0     = wb_sel_i[0];
    assign wb_wr     = wb_req && wb_we_i && lane0;
    assign wb_rd     = wb_req && !wb_we_i;
    assign wr_low    = wb_wr && wb_adr_i == OFS_LOW;
    assign wr_hlatch = wb_wr && wb_adr_i == OFS_HLATCH;
    assign wr_ulatch = wb_wr && wb_adr_i == OFS_ULATCH;
    assign wr_ptr    = wb_wr && wb_adr_i == OFS_PTR;
    assign wr_topl   = wb_wr && wb_adr_i == OFS_TOPL;
    assign wr_toph   = wb_wr && wb_adr_i == OFS_TOPH;
    assign wr_topu   = wb_wr && wb_adr_i == OFS_TOPU;
    assign wr_ctrl   = wb_wr && wb_adr_i == OFS_CTRL;
    assign rd_low    = wb_rd && wb_adr_i == OFS_LOW;

    // ----------------------------------------
    // Push and pop arbitration
    // ----------------------------------------
    assign sw_push = wr_ctrl && wb_dat_i[CTRL_PUSH];
    assign sw_pop  = wr_ctrl && wb_dat_i[CTRL_POP];
    assign hw_push = req_i.valid && (req_i.cmd == CMD_CALL || req_i.cmd == CMD_ACK_HIGH
                     || req_i.cmd == CMD_ACK_LOW);
    assign hw_pop  = req_i.valid && (req_i.cmd == CMD_RETURN || req_i.cmd == CMD_RETLIT
                     || req_i.cmd == CMD_IRQ_RET);
    // Hardware wins; a software push and pop together act as a push
    assign do_push = hw_push || (sw_push && !hw_pop);
    assign do_pop  = hw_pop || (sw_pop && !hw_push && !sw_push);
    assign stack_full_flag = pointer_value_field == 5'(DEPTH);
    assign pop_empty = do_pop && pointer_value_field == 5'h00;
    // The 31st push already counts; pushes while full count again
    assign ovf_event = do_push && pointer_value_field >= 5'(DEPTH - 1);
    assign ovf_reset = ovf_event && overflow_reset_enable;
    // Pointer and top writes lose to a push or pop in the same cycle
    assign top_write = !do_push && !do_pop && pointer_value_field != 5'h00;
    // Address of instruction after the call or interrupt ack, or current for software push
    assign push_value = hw_push ? fetch_address_counter + STEP : fetch_address_counter;
    assign top_entry = (pointer_value_field == 5'h00) ? 21'h000000
                       : stack_mem[pointer_value_field];
    assign next_fetch = ovf_reset ? RESET_VECTOR : next_pc;

    // ----------------------------------------
    // Fetch address counter
    // ----------------------------------------
    always_comb
    begin
        next_pc = fetch_address_counter;
        if (req_i.valid)
        begin
            case (req_i.cmd)
                CMD_NEXT:     next_pc = fetch_address_counter + STEP;
                CMD_JUMP:     next_pc = req_i.target;
                CMD_CALL:     next_pc = req_i.target;
                CMD_ACK_HIGH: next_pc = HIGH_VECTOR;
                CMD_ACK_LOW:  next_pc = LOW_VECTOR;
                CMD_RETURN,
                CMD_RETLIT,
                CMD_IRQ_RET:  next_pc = top_entry;     // zero on empty
                default:      next_pc = fetch_address_counter;
            endcase
        end
        if (wr_low)
            next_pc = {upper_byte_latch, high_byte_latch, wb_dat_i[7:0]};
        next_pc[0] = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fetch_address_counter <= RESET_VECTOR;
        else
            fetch_address_counter <= next_fetch;
    end

    // ----------------------------------------
    // Latch registers
    // ----------------------------------------
    // Calls and returns leave these alone, except that an overflow reset from a push clears them
    always_ff @(posedge clk_i)
    begin
        if (rst_i || ovf_reset)
        begin
            high_byte_latch  <= 8'h00;
            upper_byte_latch <= 5'h00;
        end
        else if (rd_low)
        begin
            high_byte_latch  <= fetch_address_counter[15:8];
            upper_byte_latch <= fetch_address_counter[20:16];
        end
        else
        begin
            if (wr_hlatch)
                high_byte_latch <= wb_dat_i[7:0];
            if (wr_ulatch)
                upper_byte_latch <= wb_dat_i[4:0];
        end
    end

    // ----------------------------------------
    // Stack pointer and storage
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i || ovf_reset)
            pointer_value_field <= 5'h00;
        else if (do_push && !stack_full_flag)
            pointer_value_field <= pointer_value_field + 5'h01;
        else if (do_pop && !pop_empty)
            pointer_value_field <= pointer_value_field - 5'h01;
        else if (!do_push && !do_pop && wr_ptr)
            pointer_value_field <= wb_dat_i[4:0];
    end

    // Full stack keeps its last entry; no overwrite beyond level 31
    always_ff @(posedge clk_i)
    begin
        if (do_push && !stack_full_flag)
            stack_mem[pointer_value_field + 5'h01] <= push_value;
        else if (top_write)
        begin
            if (wr_topl)
                stack_mem[pointer_value_field][7:0] <= wb_dat_i[7:0];
            if (wr_toph)
                stack_mem[pointer_value_field][15:8] <= wb_dat_i[7:0];
            if (wr_topu)
                stack_mem[pointer_value_field][20:16] <= wb_dat_i[4:0];
        end
    end

    // ----------------------------------------
    // Flags: set beats software clear
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stack_overflow_flag  <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end
        else
        begin
            if (ovf_event)
                stack_overflow_flag <= 1'b1;
            else if (wr_ptr && !wb_dat_i[OVF_BIT])
                stack_overflow_flag <= 1'b0;
            if (pop_empty)
                stack_underflow_flag <= 1'b1;
            else if (wr_ptr && !wb_dat_i[UNF_BIT])
                stack_underflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            overflow_reset_enable <= OVRST_RESET;
        else if (wr_ctrl)
            overflow_reset_enable <= wb_dat_i[CTRL_OVRST];
    end

    // ----------------------------------------
    // Fetch outputs and events
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fetch_address_o  <= RESET_VECTOR;
            fetch_in_range_o <= 1'b1;
            fetch_mask_o     <= 16'hFFFF;
        end
        else
        begin
            fetch_address_o  <= next_fetch;
            fetch_in_range_o <= (next_fetch <= MEM_TOP);
            fetch_mask_o     <= (next_fetch <= MEM_TOP) ? 16'hFFFF : NOP_WORD;
        end
    end

    // Pulses last one cycle; the partner sees them the cycle after the cause
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            event_o        <= '0;
            device_reset_o <= 1'b0;
        end
        else
        begin
            event_o.overflow       <= ovf_event;
            event_o.underflow      <= pop_empty;
            event_o.overflow_reset <= ovf_reset;
            device_reset_o         <= ovf_reset;
        end
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            if (wb_req)
            begin
                if (wb_adr_i == OFS_LOW)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {24'h000000, fetch_address_counter[7:0]};
                end
                else if (wb_adr_i == OFS_HLATCH)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {24'h000000, high_byte_latch};
                end
                else if (wb_adr_i == OFS_ULATCH)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {27'h0000000, upper_byte_latch};
                end
                else if (wb_adr_i == OFS_PTR)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {24'h000000, stack_overflow_flag, stack_underflow_flag,
                                 1'b0, pointer_value_field};
                end
                else if (wb_adr_i == OFS_TOPL)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {24'h000000, top_entry[7:0]};
                end
                else if (wb_adr_i == OFS_TOPH)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {24'h000000, top_entry[15:8]};
                end
                else if (wb_adr_i == OFS_TOPU)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {27'h0000000, top_entry[20:16]};
                end
                else if (wb_adr_i == OFS_CTRL)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {28'h0000000, 2'b00, stack_full_flag, overflow_reset_enable};
                end
                else if (wb_adr_i == OFS_PC)
                begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {11'h000, fetch_address_counter};
                end
                else
                    wb_err_o <= 1'b1;   // Unmapped
            end
        end
    end
    // Software is trusted to mask interrupts around stack access
endmodule
`default_nettype wire

// *** test/pcrs_core_sva.sv ***
/* Port checker for pcrs_core.
   Assumes a classic Wishbone master and the decoder request port. */
`timescale 1ns/1ps
`default_nettype none
module pcrs_core_chk #(
    parameter logic [20:0] MEM_TOP = pcrs_pkg::TOP_16K
) (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire pcrs_pkg::pcrs_req_type  req_i,
    input wire logic [20:0]             fetch_address_o,
    input wire logic                    fetch_in_range_o,
    input wire logic [15:0]             fetch_mask_o,
    input wire pcrs_pkg::pcrs_event_type event_o,
    input wire logic                    device_reset_o,
    input wire logic [7:0]              wb_adr_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_ack_o,
    input wire logic                    wb_err_o
);
    import pcrs_pkg::*;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic quiet;
    assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign quiet = req_i.valid && !wb_cyc_i;
    chk_reset_start: assert property ($fell(rst_i) |-> fetch_address_o == RESET_VECTOR && !wb_ack_o)
        else $error("counter not at start address after reset");
    chk_lsb_low: assert property (fetch_address_o[0] == 1'b0)
        else $error("fetch address odd");
    chk_seq_step: assert property (quiet && req_i.cmd == CMD_NEXT |=>
        fetch_address_o == $past(fetch_address_o) + STEP) else $error("sequential step not two");
    chk_jump_load: assert property (quiet && req_i.cmd == CMD_JUMP |=>
        fetch_address_o == ($past(req_i.target) & 21'h1FFFFE)) else $error("jump target not loaded");
    chk_call_load: assert property (quiet && req_i.cmd == CMD_CALL |=> device_reset_o ||
        fetch_address_o == ($past(req_i.target) & 21'h1FFFFE)) else $error("call target not loaded");
    chk_irq_vector: assert property (quiet && req_i.cmd inside {CMD_ACK_HIGH, CMD_ACK_LOW} |=>
        device_reset_o || fetch_address_o == ($past(req_i.cmd) == CMD_ACK_HIGH ? HIGH_VECTOR : LOW_VECTOR))
        else $error("interrupt vector wrong");
    chk_bus_answer: assert property (take |=> wb_ack_o ^ wb_err_o)
        else $error("bus answer missing");
    chk_unmapped_err: assert property (take && wb_adr_i > OFS_PC |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    chk_range_flag: assert property (fetch_in_range_o == (fetch_address_o <= MEM_TOP))
        else $error("range flag wrong");
    chk_zero_mask: assert property (fetch_mask_o == (fetch_in_range_o ? 16'hFFFF : NOP_WORD))
        else $error("fetch mask wrong");
    chk_reset_cause: assert property (device_reset_o |-> event_o.overflow_reset
        && fetch_address_o == RESET_VECTOR) else $error("overflow reset incomplete");
    cov_call: cover property (quiet && req_i.cmd == CMD_CALL);
    cov_return: cover property (quiet && req_i.cmd == CMD_RETURN);
    cov_err: cover property (wb_err_o);
    cov_reset: cover property (device_reset_o);
endmodule
bind pcrs_core pcrs_core_chk #(.MEM_TOP(MEM_TOP)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .fetch_address_o(fetch_address_o), .fetch_in_range_o(fetch_in_range_o), .fetch_mask_o(fetch_mask_o),
    .event_o(event_o), .device_reset_o(device_reset_o), .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
`default_nettype wire

// *** test/pcrs_dec_model.sv ***
/* Decoder and interrupt logic stand-in driving the request port.
   Assumes the bench calls issue between its own register accesses. */
`timescale 1ns/1ps
`default_nettype none
module pcrs_dec_model (
    input  wire logic                  clk_i,
    output var pcrs_pkg::pcrs_req_type req_o
);
    import pcrs_pkg::*;
    initial req_o = '0;
    // Acks never overlap a stack register access
    task automatic issue(input pcrs_cmd_type c, input logic [20:0] t, input logic [1:0] gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        req_o <= '{1'b1, c, t};
        @(posedge clk_i);
        req_o <= '{1'b0, CMD_HOLD, ~t};
    endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
/* Self-checking bench for pcrs_core with random command stream.
   Assumes pcrs_pkg, the checker and pcrs_dec_model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcrs_pkg::*;
    // ----------------------------------------
    // Signals and expected state
    // ----------------------------------------
    localparam logic [20:0] TOP = TOP_8K;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pcrs_req_type req;
    pcrs_event_type event_o;
    logic [20:0] fetch_address_o;
    logic [15:0] fetch_mask_o;
    logic fetch_in_range_o, device_reset_o, wb_ack_o, wb_err_o, e;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, rs = 32'h44;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, ovf = 1'b0, unf = 1'b0, en = 1'b1;
    logic [3:0] wb_sel_i = 4'hF;
    logic [20:0] pc = 21'h0;
    logic [20:0] stk [32];
    logic [4:0] sp = 5'h0, ul = 5'h0;
    logic [7:0] hl = 8'h00;
    pcrs_cmd_type c;
    int n_mismatch = 0;
    int num_checks = 0;
    always #2.5 clk_i = ~clk_i;
    pcrs_dec_model i_dec (.clk_i(clk_i), .req_o(req));
    pcrs_core #(.MEM_TOP(TOP)) i_pcrs_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .fetch_address_o(fetch_address_o), .fetch_in_range_o(fetch_in_range_o), .fetch_mask_o(fetch_mask_o),
        .event_o(event_o), .device_reset_o(device_reset_o), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] ptrv();
        return {24'h0, ovf, unf, 1'b0, sp};
    endfunction
    function automatic logic [20:0] topv();
        return (sp == 5'h0) ? 21'h0 : stk[sp];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for the answer; only the bounded count ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        e = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 20)
            chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFFFFFF);
        bus(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask
    task automatic push(input logic [20:0] ret, input logic [20:0] dst);
        if (sp >= 5'h1E && en)
        begin
            if (sp == 5'h1E)
                stk[31] = ret;
            {pc, sp, hl, ul, ovf} = {21'h0, 5'h0, 8'h0, 5'h0, 1'b1};
        end
        else
        begin
            ovf = ovf | (sp >= 5'h1E);
            if (sp != 5'h1F)
            begin
                sp = sp + 5'h1;
                stk[sp] = ret;
            end
            pc = dst;
        end
    endtask
    task automatic op(input pcrs_cmd_type k, input logic [20:0] t);
        logic [2:0] ev;
        ev = 3'b000;
        if (k inside {CMD_CALL, CMD_ACK_HIGH, CMD_ACK_LOW} && sp >= 5'h1E)
            ev = {en, 2'b10};
        if (k inside {CMD_RETURN, CMD_RETLIT, CMD_IRQ_RET} && sp == 5'h0)
            ev = 3'b001;
        rs = lfsr(rs);
        i_dec.issue(k, t, rs[1:0]);
        case (k)
            CMD_NEXT: pc = pc + STEP;
            CMD_JUMP: pc = t & 21'h1FFFFE;
            CMD_CALL: push(pc + STEP, t & 21'h1FFFFE);
            CMD_ACK_HIGH: push(pc + STEP, HIGH_VECTOR);
            CMD_ACK_LOW: push(pc + STEP, LOW_VECTOR);
            CMD_HOLD: ;
            default: if (sp == 5'h0) {pc, unf} = {21'h0, 1'b1}; else {pc, sp} = {stk[sp] & 21'h1FFFFE, sp - 5'h1};
        endcase
        #1;
        chk(fetch_address_o, pc);
        chk({fetch_in_range_o, fetch_mask_o}, {pc <= TOP, (pc <= TOP) ? 16'hFFFF : NOP_WORD});
        chk({device_reset_o, event_o}, {ev[2], ev});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_PTR, 32'h0);
        rd(OFS_TOPL, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        chk(e, 1'b1);
        $display("reset test done");
        bus(1'b1, OFS_HLATCH, 32'h5A);
        bus(1'b1, OFS_ULATCH, 32'h13);
        bus(1'b1, OFS_LOW, 32'hFF);
        pc = 21'h135AFE;
        rd(OFS_PC, pc);
        op(CMD_NEXT, 21'h0);
        rd(OFS_LOW, 32'h0);
        {hl, ul} = {8'h5B, 5'h13};
        rd(OFS_HLATCH, hl);
        rd(OFS_ULATCH, ul);
        $display("latch test done");
        repeat (300)
        begin
            rs = lfsr(rs);
            c = pcrs_cmd_type'(rs[7:4] % 4'h9);
            if (sp > 5'h18 && c inside {CMD_CALL, CMD_ACK_HIGH, CMD_ACK_LOW})
                c = CMD_RETURN;
            op(c, rs[28:8]);
            if (rs[2:0] == 3'h0)
            begin
                rd(OFS_PTR, ptrv());
                rd(OFS_TOPL, topv() & 21'hFF);
                rd(OFS_TOPH, (topv() >> 8) & 21'hFF);
                rd(OFS_TOPU, topv() >> 16);
                rd(OFS_HLATCH, hl);
            end
        end
        $display("random test done");
        bus(1'b1, OFS_PTR, 32'h0);
        {sp, ovf, unf} = 7'h0;
        op(CMD_RETLIT, 21'h0);
        rd(OFS_PTR, ptrv());
        bus(1'b1, OFS_PTR, 32'h40);
        rd(OFS_PTR, 32'h40);
        bus(1'b1, OFS_PTR, 32'h0);
        unf = 1'b0;
        op(CMD_CALL, 21'h00ABC0);
        bus(1'b1, OFS_TOPL, 32'h44);
        bus(1'b1, OFS_TOPH, 32'h33);
        bus(1'b1, OFS_TOPU, 32'h01);
        stk[sp] = 21'h013344;
        op(CMD_IRQ_RET, 21'h0);
        bus(1'b1, OFS_TOPL, 32'h77);
        rd(OFS_TOPL, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h3);
        sp = sp + 5'h1;
        stk[sp] = pc;
        rd(OFS_TOPL, topv() & 21'hFF);
        bus(1'b1, OFS_CTRL, 32'h5);
        sp = sp - 5'h1;
        rd(OFS_PTR, ptrv());
        $display("stack access test done");
        bus(1'b1, OFS_CTRL, 32'h0);
        en = 1'b0;
        repeat (32)
        begin
            rs = lfsr(rs);
            op(CMD_CALL, rs[20:0]);
        end
        rd(OFS_PTR, ptrv());
        rd(OFS_CTRL, 32'h2, 32'h3);
        rd(OFS_TOPL, topv() & 21'hFF);
        bus(1'b1, OFS_CTRL, 32'h1);
        en = 1'b1;
        op(CMD_ACK_LOW, 21'h0);
        rd(OFS_PTR, ptrv());
        rd(OFS_HLATCH, hl);
        repeat (31) op(CMD_CALL, 21'h000100);
        rd(OFS_PTR, ptrv());
        bus(1'b1, OFS_PTR, 32'h9F);
        sp = 5'h1F;
        rd(OFS_TOPL, topv() & 21'hFF);
        $display("overflow test done");
        summarize();
    end
endmodule
`default_nettype wire
